// ===== logic/sfch_host.sv
/*
  sfch_host: serial flash command host; sequences write enable, command
  frames and status polling over a link-clocked byte engine, and keeps the
  file-store allocation bookkeeping.
  assumes: i_clk and i_link_clk unrelated; i_srst synchronous to i_clk;
  the flash answers in mode 0 on the link pins.
*/
`timescale 1ns/1ps

// Functional notes
// - identify: send 9f, then read three id bytes.
// - status read: send 05, then read exactly one byte.
// - status bit 0 is busy, bit 1 is write-enable latch.
// - write enable: send 06, poll status until latch bit set.
// - chip erase: send c7, poll status until busy clears.
// - data read: send 03, 24-bit address, then stream 0 to 65535 bytes.
// - page program: send 02, 24-bit address, 1 to 255 bytes.
// - sector erase: send 20, 24-bit address, poll until busy clears.
// - every erase sector is treated as 4K bytes.
// - file store always starts at flash address zero; only size set.
// - at most 128 files in the file store.
// - files take whole 4KB blocks, at least one block.
// - secure or fail-safe files take double size, at least 8KB.
// - a single file is at most 16MB.
// - the flash parameter table can be read.
// - the port window decodes one 4 KB page at 0x4402_0000.
module sfch_host
  import sfch_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_link_clk,
  input wire logic i_cmd_valid,
  input wire sfch_cmd_t i_cmd,
  output logic o_cmd_ready,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_done,
  output logic o_err,
  output logic o_busy,
  output logic [7:0] o_status,
  input wire logic i_fs_alloc,
  input wire logic i_fs_format,
  input wire sfch_fs_req_t i_fs_req,
  input wire logic [15:0] i_fs_region_blocks,
  output logic o_fs_ok,
  output logic o_fs_fail,
  output logic [23:0] o_fs_addr,
  output logic [15:0] o_fs_blocks,
  output logic [7:0] o_fs_files,
  input wire logic [31:0] i_win_addr,
  output logic o_win_hit,
  input wire logic i_miso,
  output sfch_pins_t o_flash
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WREN,
    ST_WEL_POLL,
    ST_CMD,
    ST_BUSY_POLL
  } sfch_state_t;

  typedef struct packed {
    sfch_state_t st;
    sfch_op_t op;
    logic [23:0] addr;
    logic [15:0] len;
    logic [16:0] idx;
    logic req_tgl;
    sfch_link_tx_t tx;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic [7:0] stat;
    logic rd_valid;
    logic [7:0] rd_data;
    logic done;
    logic err;
    logic win_hit;
    logic [7:0] fs_files;
    logic [15:0] fs_used;
    logic fs_ok;
    logic fs_fail;
    logic [23:0] fs_addr;
    logic [15:0] fs_blocks;
  } sfch_host_state_t;

  sfch_host_state_t r_reg;
  sfch_host_state_t r_next;

  logic ack_tgl;
  logic [7:0] link_rx;
  logic pending;
  logic ack_evt;
  logic has_addr;
  logic [16:0] hdr;
  logic [16:0] ndata;
  logic [16:0] total;
  logic in_data;
  logic frame_end;
  logic [7:0] byte_tx;
  logic byte_ok;
  logic [25:0] fs_round;
  logic [15:0] fs_blk;
  logic fs_fits;

  sfch_link_shifter u_link (
    .i_link_clk(i_link_clk),
    .i_srst(i_srst),
    .i_req_tgl(r_reg.req_tgl),
    .i_tx(r_reg.tx),
    .i_miso(i_miso),
    .o_ack_tgl(ack_tgl),
    .o_rx(link_rx),
    .o_pins(o_flash)
  );

  assign pending = r_reg.req_tgl != r_reg.ack_s2;
  assign ack_evt = r_reg.ack_s2 != r_reg.ack_s3;

  // frame layout of the current phase
  always_comb begin
    has_addr = (r_reg.op == OP_READ_DATA) || (r_reg.op == OP_PAGE_PROGRAM) ||
      (r_reg.op == OP_SECTOR_ERASE) || (r_reg.op == OP_READ_PARAMS);
    hdr = 17'h1 + (has_addr ? ADDR_BYTES : 17'h0) +
      ((r_reg.op == OP_READ_PARAMS) ? PARAM_DUMMY : 17'h0);
    case (r_reg.op)
      OP_READ_ID: ndata = ID_BYTES;
      OP_READ_STATUS: ndata = STATUS_BYTES;
      OP_READ_DATA, OP_READ_PARAMS, OP_PAGE_PROGRAM: ndata = {1'b0, r_reg.len};
      default: ndata = 17'h0;
    endcase
    in_data = (r_reg.st == ST_CMD) && (r_reg.idx >= hdr);
    byte_ok = 1'b1;
    case (r_reg.st)
      ST_WREN: begin
        total = 17'h1;
        byte_tx = OPC_WRITE_ENABLE;
      end
      ST_WEL_POLL, ST_BUSY_POLL: begin
        total = POLL_FRAME;
        byte_tx = (r_reg.idx == 17'h0) ? OPC_READ_STATUS : FILL_BYTE;
      end
      ST_CMD: begin
        total = hdr + ndata;
        if (r_reg.idx == 17'h0) begin
          case (r_reg.op)
            OP_READ_ID: byte_tx = OPC_READ_ID;
            OP_READ_STATUS: byte_tx = OPC_READ_STATUS;
            OP_WRITE_ENABLE: byte_tx = OPC_WRITE_ENABLE;
            OP_CHIP_ERASE: byte_tx = OPC_CHIP_ERASE;
            OP_READ_DATA: byte_tx = OPC_READ_DATA;
            OP_PAGE_PROGRAM: byte_tx = OPC_PAGE_PROGRAM;
            OP_SECTOR_ERASE: byte_tx = OPC_SECTOR_ERASE;
            OP_READ_PARAMS: byte_tx = OPC_READ_PARAMS;
            default: byte_tx = FILL_BYTE;
          endcase
        end else if (has_addr && (r_reg.idx == 17'h1)) begin
          byte_tx = r_reg.addr[23:16];
        end else if (has_addr && (r_reg.idx == 17'h2)) begin
          byte_tx = r_reg.addr[15:8];
        end else if (has_addr && (r_reg.idx == 17'h3)) begin
          byte_tx = r_reg.addr[7:0];
        end else if (in_data && (r_reg.op == OP_PAGE_PROGRAM)) begin
          byte_tx = i_wr_data;
          byte_ok = i_wr_valid;
        end else begin
          byte_tx = FILL_BYTE;
        end
      end
      default: begin
        total = 17'h1;
        byte_tx = FILL_BYTE;
        byte_ok = 1'b0;
      end
    endcase
    frame_end = r_reg.idx == (total - 17'h1);
  end

  // file-store block count for a request
  always_comb begin
    fs_round = {1'b0, i_fs_req.size} + FS_BLOCK_ROUND;
    fs_blk = 16'(fs_round[25:SECTOR_SHIFT]);
    if (fs_blk == 16'h0) begin
      fs_blk = 16'h1;
    end
    if (i_fs_req.secure) begin
      fs_blk = {fs_blk[14:0], 1'b0};
      if (fs_blk < FS_SECURE_MIN_BLK) begin
        fs_blk = FS_SECURE_MIN_BLK;
      end
    end
    fs_fits = (i_fs_req.size <= FS_MAX_FILE_BYTES) &&
      (r_reg.fs_files < FS_MAX_FILES) &&
      (({1'b0, r_reg.fs_used} + {1'b0, fs_blk}) <= {1'b0, i_fs_region_blocks});
  end

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.err = 1'b0;
    r_next.rd_valid = 1'b0;
    r_next.fs_ok = 1'b0;
    r_next.fs_fail = 1'b0;
    r_next.ack_s1 = ack_tgl;
    r_next.ack_s2 = r_reg.ack_s1;
    r_next.ack_s3 = r_reg.ack_s2;
    r_next.win_hit = i_win_addr[31:WIN_SPAN_SHIFT] == WIN_BASE[31:WIN_SPAN_SHIFT];
    case (r_reg.st)
      ST_IDLE: begin
        if (i_cmd_valid) begin
          r_next.op = i_cmd.op;
          r_next.addr = i_cmd.addr;
          r_next.len = i_cmd.len;
          r_next.idx = 17'h0;
          if (i_cmd.op == OP_SECTOR_ERASE) begin
            r_next.addr = i_cmd.addr & SECTOR_MASK;
          end
          if ((i_cmd.op == OP_PAGE_PROGRAM) &&
              ((i_cmd.len == 16'h0) || (i_cmd.len > PROG_MAX_LEN))) begin
            r_next.err = 1'b1;
          end else if ((i_cmd.op == OP_PAGE_PROGRAM) || (i_cmd.op == OP_SECTOR_ERASE) ||
                       (i_cmd.op == OP_CHIP_ERASE)) begin
            r_next.st = ST_WREN;
          end else begin
            r_next.st = ST_CMD;
          end
        end
      end
      ST_WREN, ST_WEL_POLL, ST_CMD, ST_BUSY_POLL: begin
        if (ack_evt) begin
          if (in_data && (r_reg.op != OP_PAGE_PROGRAM)) begin
            r_next.rd_valid = 1'b1;
            r_next.rd_data = link_rx;
          end
          if ((r_reg.st != ST_WREN) && (r_reg.idx == 17'h1) &&
              ((r_reg.st != ST_CMD) || (r_reg.op == OP_READ_STATUS))) begin
            r_next.stat = link_rx;
          end
          if (frame_end) begin
            r_next.idx = 17'h0;
            case (r_reg.st)
              ST_WREN: r_next.st = ST_WEL_POLL;
              ST_WEL_POLL: begin
                if (link_rx[STAT_WEL_BIT]) begin
                  r_next.st = (r_reg.op == OP_WRITE_ENABLE) ? ST_IDLE : ST_CMD;
                  r_next.done = r_reg.op == OP_WRITE_ENABLE;
                end
              end
              ST_CMD: begin
                if (r_reg.op == OP_WRITE_ENABLE) begin
                  r_next.st = ST_WEL_POLL;
                end else if ((r_reg.op == OP_CHIP_ERASE) || (r_reg.op == OP_SECTOR_ERASE) ||
                             (r_reg.op == OP_PAGE_PROGRAM)) begin
                  r_next.st = ST_BUSY_POLL;
                end else begin
                  r_next.st = ST_IDLE;
                  r_next.done = 1'b1;
                end
              end
              default: begin
                if (!link_rx[STAT_BUSY_BIT]) begin
                  r_next.st = ST_IDLE;
                  r_next.done = 1'b1;
                end
              end
            endcase
          end else begin
            r_next.idx = r_reg.idx + 17'h1;
          end
        end else if (!pending && byte_ok) begin
          r_next.tx.data = byte_tx;
          r_next.tx.last = frame_end;
          r_next.req_tgl = ~r_reg.req_tgl;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase
    // file-store bookkeeping
    if (i_fs_format) begin
      r_next.fs_files = 8'h0;
      r_next.fs_used = 16'h0;
    end else if (i_fs_alloc) begin
      if (fs_fits) begin
        r_next.fs_ok = 1'b1;
        r_next.fs_addr = FS_BASE_ADDR + 24'({r_reg.fs_used, 12'h000});
        r_next.fs_blocks = fs_blk;
        r_next.fs_files = r_reg.fs_files + 8'h1;
        r_next.fs_used = r_reg.fs_used + fs_blk;
      end else begin
        r_next.fs_fail = 1'b1;
      end
    end
    if (i_srst) begin
      r_next = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    r_reg <= r_next;
  end

  assign o_cmd_ready = r_reg.st == ST_IDLE;
  assign o_wr_ready = in_data && (r_reg.op == OP_PAGE_PROGRAM) && !pending && !ack_evt;
  assign o_rd_valid = r_reg.rd_valid;
  assign o_rd_data = r_reg.rd_data;
  assign o_done = r_reg.done;
  assign o_err = r_reg.err;
  assign o_busy = r_reg.st != ST_IDLE;
  assign o_status = r_reg.stat;
  assign o_fs_ok = r_reg.fs_ok;
  assign o_fs_fail = r_reg.fs_fail;
  assign o_fs_addr = r_reg.fs_addr;
  assign o_fs_blocks = r_reg.fs_blocks;
  assign o_fs_files = r_reg.fs_files;
  assign o_win_hit = r_reg.win_hit;

endmodule // sfch_host

// ===== logic/sfch_link_shifter.sv
/*
  sfch_link_shifter: byte engine on the link clock; shifts one byte per
  request in mode 0, keeps chip select low between bytes of one frame.
  assumes: request word held stable while i_req_tgl differs from o_ack_tgl.
*/
`timescale 1ns/1ps
module sfch_link_shifter
  import sfch_pkg::*;
(
  input wire logic i_link_clk,
  input wire logic i_srst,
  input wire logic i_req_tgl,
  input wire sfch_link_tx_t i_tx,
  input wire logic i_miso,
  output logic o_ack_tgl,
  output logic [7:0] o_rx,
  output sfch_pins_t o_pins
);

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic miso_s1;
    logic miso_s2;
    logic ack_tgl;
    logic active;
    logic last;
    logic [4:0] cnt;
    logic [7:0] sh;
    logic [7:0] rx;
    logic [7:0] rx_out;
    logic cs_n;
    logic sck;
  } sfch_link_state_t;

  sfch_link_state_t r_reg;
  sfch_link_state_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.rst_s1 = i_srst;
    r_next.rst_s2 = r_reg.rst_s1;
    r_next.req_s1 = i_req_tgl;
    r_next.req_s2 = r_reg.req_s1;
    r_next.miso_s1 = i_miso;
    r_next.miso_s2 = r_reg.miso_s1;
    if (!r_reg.active) begin
      if (r_reg.req_s2 != r_reg.ack_tgl) begin
        r_next.active = 1'b1;
        r_next.cs_n = 1'b0;
        r_next.sh = i_tx.data;
        r_next.last = i_tx.last;
        r_next.cnt = 5'h0;
      end
    end else begin
      r_next.cnt = r_reg.cnt + 5'h1;
      r_next.sck = (r_reg.cnt[1:0] == PH_SCK_RISE) || (r_reg.cnt[1:0] == 2'h2);
      if (r_reg.cnt[1:0] == PH_SCK_FALL) begin
        r_next.rx = {r_reg.rx[6:0], r_reg.miso_s2};
        r_next.sh = {r_reg.sh[6:0], 1'b0};
        if (r_reg.cnt == LAST_CNT) begin
          r_next.active = 1'b0;
          r_next.rx_out = {r_reg.rx[6:0], r_reg.miso_s2};
          r_next.ack_tgl = ~r_reg.ack_tgl;
          r_next.cs_n = r_reg.last;
        end
      end
    end
    if (r_reg.rst_s2) begin
      r_next = '0;
      r_next.rst_s1 = i_srst;
      r_next.rst_s2 = r_reg.rst_s1;
      r_next.cs_n = 1'b1;
    end
  end

  always_ff @(posedge i_link_clk) begin
    r_reg <= r_next;
  end

  assign o_ack_tgl = r_reg.ack_tgl;
  assign o_rx = r_reg.rx_out;
  assign o_pins.cs_n = r_reg.cs_n;
  assign o_pins.sck = r_reg.sck;
  assign o_pins.mosi = r_reg.sh[7];

endmodule // sfch_link_shifter

// ===== logic/sfch_pkg.sv
/*
  sfch_pkg: opcodes, status bit positions, frame sizes, file-store limits,
  port window decode and the carrier types of the serial flash command host.
  assumes: included before every design file of the block.
*/
package sfch_pkg;

  // flash opcodes
  localparam logic [7:0] OPC_READ_ID      = 8'h9f;
  localparam logic [7:0] OPC_READ_STATUS  = 8'h05;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_CHIP_ERASE   = 8'hc7;
  localparam logic [7:0] OPC_READ_DATA    = 8'h03;
  localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OPC_READ_PARAMS  = 8'h5a;
  localparam logic [7:0] FILL_BYTE        = 8'h00;

  // status byte fields
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_WEL_BIT  = 1;

  // frame sizes in bytes
  localparam logic [16:0] ID_BYTES     = 17'h3;
  localparam logic [16:0] STATUS_BYTES = 17'h1;
  localparam logic [16:0] ADDR_BYTES   = 17'h3;
  localparam logic [16:0] PARAM_DUMMY  = 17'h1;
  localparam logic [16:0] POLL_FRAME   = 17'h2;
  localparam logic [15:0] PROG_MAX_LEN = 16'hff;

  // erase sector and file-store block geometry
  localparam int unsigned SECTOR_SHIFT      = 12;
  localparam logic [23:0] SECTOR_MASK       = 24'hfff000;
  localparam logic [23:0] FS_BASE_ADDR      = 24'h000000;
  localparam logic [25:0] FS_BLOCK_ROUND    = 26'hfff;
  localparam logic [15:0] FS_SECURE_MIN_BLK = 16'h2;
  localparam logic [7:0]  FS_MAX_FILES      = 8'h80;
  localparam logic [24:0] FS_MAX_FILE_BYTES = 25'h1000000;

  // flash serial port register window
  localparam logic [31:0] WIN_BASE       = 32'h44020000;
  localparam int unsigned WIN_SPAN_SHIFT = 12;

  // link timing, in link clock cycles
  localparam logic [1:0] PH_SCK_RISE = 2'h1;
  localparam logic [1:0] PH_SCK_FALL = 2'h3;
  localparam logic [4:0] LAST_CNT    = 5'h1f;

  typedef enum logic [2:0] {
    OP_READ_ID,
    OP_READ_STATUS,
    OP_WRITE_ENABLE,
    OP_CHIP_ERASE,
    OP_READ_DATA,
    OP_PAGE_PROGRAM,
    OP_SECTOR_ERASE,
    OP_READ_PARAMS
  } sfch_op_t;

  typedef struct packed {
    sfch_op_t    op;
    logic [23:0] addr;
    logic [15:0] len;
  } sfch_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } sfch_link_tx_t;

  typedef struct packed {
    logic [24:0] size;
    logic        secure;
  } sfch_fs_req_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } sfch_pins_t;

endpackage

// ===== sim/sfch_flash_model.sv
/*
  sfch_flash_model: behavioural serial flash, mode 0, msb first.
  assumes: host clock idles low outside frames.
*/
`timescale 1ns/1ps
module sfch_flash_model #(
  parameter logic [23:0] ID_CODE = 24'h3c2117 // arbitrary value
) (
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso
);
  int bitc = 0;
  int byc = 0;
  int busy = 0;
  logic wel = 0;
  logic [7:0] op, rx, cop, sh = 8'h00;
  logic [23:0] adr = 24'h0;
  logic [7:0] ops[$];
  logic [7:0] pq[$];
  function automatic logic [7:0] resp(input int k);
    case (op)
      8'h9f: return 8'(ID_CODE >> (8 * (3 - k)));
      8'h05: return {6'h00, wel, busy != 0};
      8'h03: return 8'(adr[7:0] + k - 4) ^ 8'h5a;
      8'h5a: return 8'ha0 + 8'(k - 5);
      default: return 8'h00;
    endcase
  endfunction
  assign o_miso = sh[7];
  always @(negedge i_cs_n) begin
    bitc = 0;
    byc = 0;
  end
  always @(posedge i_sck) if (!i_cs_n) begin
    rx = {rx[6:0], i_mosi};
    bitc++;
    if (bitc == 8) begin
      bitc = 0;
      if (byc == 0) begin
        op = rx;
        ops.push_back(rx);
        if (rx != 8'h05 && rx != 8'h06) cop = rx;
      end else if (byc < 4 && op != 8'h05) adr = {adr[15:0], rx};
      else if (op == 8'h02) pq.push_back(rx);
      byc++;
    end
  end
  always @(negedge i_sck) if (!i_cs_n) sh = bitc == 0 ? resp(byc) : {sh[6:0], 1'b0};
  always @(posedge i_cs_n) begin
    sh = ~sh;
    if (op == 8'h06) wel = 1;
    if (op == 8'h05 && busy > 0) busy--;
    if ((op == 8'h02 || op == 8'h20 || op == 8'hc7) && wel) begin
      busy = 3;
      wel = 0;
    end
  end
endmodule // sfch_flash_model

// ===== sim/sfch_host_props.sv
/*
  sfch_host_props: port timing checks of the serial flash command host.
  assumes: bound to sfch_host; i_srst high clears both clock domains.
*/
`timescale 1ns/1ps
module sfch_host_props
  import sfch_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_link_clk,
  input wire logic i_cmd_valid,
  input wire sfch_cmd_t i_cmd,
  input wire logic o_cmd_ready,
  input wire logic o_err,
  input wire logic o_busy,
  input wire logic i_fs_alloc,
  input wire logic i_fs_format,
  input wire sfch_fs_req_t i_fs_req,
  input wire logic o_fs_ok,
  input wire logic o_fs_fail,
  input wire logic [23:0] o_fs_addr,
  input wire logic [15:0] o_fs_blocks,
  input wire logic [7:0] o_fs_files,
  input wire logic [31:0] i_win_addr,
  input wire logic o_win_hit,
  input wire sfch_pins_t o_flash
);
  logic take;
  logic bad;
  logic fa;
  assign take = i_cmd_valid && o_cmd_ready;
  assign bad = i_cmd.op == OP_PAGE_PROGRAM && (i_cmd.len == 16'h0 || i_cmd.len > 16'hff);
  assign fa = i_fs_alloc && !i_fs_format;
  chk_prog_refuse: assert property (@(posedge i_clk) disable iff (i_srst)
    take && bad |=> o_err && !o_busy) else $error("bad length not refused");
  chk_cmd_start: assert property (@(posedge i_clk) disable iff (i_srst)
    take && !bad |=> o_busy && !o_err) else $error("command not started");
  chk_win_hit: assert property (@(posedge i_clk) disable iff (i_srst)
    !$past(i_srst) |-> o_win_hit == ($past(i_win_addr[31:12]) == 20'h44020))
    else $error("window decode wrong");
  chk_fs_big: assert property (@(posedge i_clk) disable iff (i_srst)
    fa && i_fs_req.size > 25'h1000000 |=> o_fs_fail && !o_fs_ok) else $error("big file kept");
  chk_fs_count: assert property (@(posedge i_clk) disable iff (i_srst)
    fa && o_fs_files == 8'h80 |=> o_fs_fail) else $error("file count exceeded");
  chk_fs_align: assert property (@(posedge i_clk) disable iff (i_srst)
    o_fs_ok |-> o_fs_addr[11:0] == 12'h0 && o_fs_blocks != 16'h0) else $error("block misfit");
  chk_fs_secure: assert property (@(posedge i_clk) disable iff (i_srst)
    fa && i_fs_req.secure |=> !o_fs_ok || (o_fs_blocks >= 16'h2 && !o_fs_blocks[0]))
    else $error("secure size wrong");
  chk_fs_base: assert property (@(posedge i_clk) disable iff (i_srst)
    i_fs_format ##1 fa ##1 o_fs_ok |-> o_fs_addr == 24'h0) else $error("store not at zero");
  chk_cs_sck: assert property (@(posedge i_link_clk) disable iff (i_srst)
    o_flash.cs_n |-> !o_flash.sck) else $error("clock outside frame");
  cov_err: cover property (@(posedge i_clk) o_err);
  cov_fail: cover property (@(posedge i_clk) o_fs_fail);
  cov_hit: cover property (@(posedge i_clk) o_win_hit);
endmodule // sfch_host_props

bind sfch_host sfch_host_props u_props (.i_clk(i_clk), .i_srst(i_srst),
  .i_link_clk(i_link_clk), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
  .o_cmd_ready(o_cmd_ready), .o_err(o_err), .o_busy(o_busy), .i_fs_alloc(i_fs_alloc),
  .i_fs_format(i_fs_format), .i_fs_req(i_fs_req), .o_fs_ok(o_fs_ok),
  .o_fs_fail(o_fs_fail), .o_fs_addr(o_fs_addr), .o_fs_blocks(o_fs_blocks),
  .o_fs_files(o_fs_files), .i_win_addr(i_win_addr), .o_win_hit(o_win_hit),
  .o_flash(o_flash));

// ===== sim/tb_top.sv
/*
  tb_top: self-checking bench of sfch_host with a flash model.
  assumes: 50 MHz system clock, 32 ns link clock.
*/
`timescale 1ns/1ps
module tb_top
  import sfch_pkg::*;
;
  localparam logic [23:0] FID = 24'h3c2117; // arbitrary value
  logic i_clk = 0, i_srst = 1, i_link_clk = 0, i_cmd_valid = 0, i_wr_valid = 1;
  logic i_fs_alloc = 0, i_fs_format = 0, miso, fin, gerr;
  sfch_cmd_t i_cmd = '0;
  sfch_fs_req_t i_fs_req = '0;
  logic [7:0] i_wr_data = 8'h00, o_rd_data, o_status, o_fs_files;
  logic [15:0] i_fs_region_blocks = 16'hffff, o_fs_blocks;
  logic [31:0] i_win_addr = 32'h0;
  logic o_cmd_ready, o_wr_ready, o_rd_valid, o_done, o_err, o_busy, o_fs_ok, o_fs_fail;
  logic o_win_hit, wtk = 1'b0;
  logic [23:0] o_fs_addr;
  sfch_pins_t o_flash;
  int error_cnt = 0, samples_checked = 0, used = 0, files = 0;
  logic [7:0] rq[$], wq[$];
  sfch_host u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_link_clk(i_link_clk),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready),
    .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_done(o_done), .o_err(o_err),
    .o_busy(o_busy), .o_status(o_status), .i_fs_alloc(i_fs_alloc),
    .i_fs_format(i_fs_format), .i_fs_req(i_fs_req), .i_fs_region_blocks(i_fs_region_blocks),
    .o_fs_ok(o_fs_ok), .o_fs_fail(o_fs_fail), .o_fs_addr(o_fs_addr),
    .o_fs_blocks(o_fs_blocks), .o_fs_files(o_fs_files), .i_win_addr(i_win_addr),
    .o_win_hit(o_win_hit), .i_miso(miso), .o_flash(o_flash));
  sfch_flash_model #(.ID_CODE(FID)) u_flash (.i_cs_n(o_flash.cs_n), .i_sck(o_flash.sck),
    .i_mosi(o_flash.mosi), .o_miso(miso));
  always #10 i_clk = ~i_clk;
  initial begin
    #7;
    forever #16 i_link_clk = ~i_link_clk;
  end
  // a new program byte is offered only once the last one was taken
  always @(negedge i_clk) begin
    if (!i_wr_valid || wtk) begin
      i_wr_valid <= 1'($urandom);
      i_wr_data <= 8'($urandom);
    end
  end
  always @(posedge i_clk) begin
    if (o_rd_valid === 1'b1) rq.push_back(o_rd_data);
    if (i_wr_valid && o_wr_ready === 1'b1) wq.push_back(i_wr_data);
    if (o_done === 1'b1 || o_err === 1'b1) fin = 1;
    if (o_err === 1'b1) gerr = 1;
    wtk = i_wr_valid && o_wr_ready === 1'b1;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic run(input sfch_op_t op, input logic [23:0] a, input logic [15:0] n);
    int t;
    @(negedge i_clk);
    u_flash.ops.delete();
    u_flash.pq.delete();
    rq.delete();
    wq.delete();
    fin = 0;
    gerr = 0;
    i_cmd = '{op, a, n};
    i_cmd_valid = 1;
    t = 0;
    while (!o_cmd_ready && t < 100) begin
      @(negedge i_clk);
      t++;
    end
    @(negedge i_clk);
    i_cmd_valid = 0;
    t = 0;
    while (!fin && t < 40000) begin
      @(negedge i_clk);
      t++;
    end
    chk("finish", fin, 1);
    $display("test %s done", op.name());
  endtask
  task automatic fmt();
    i_fs_format = 1;
    @(negedge i_clk);
    i_fs_format = 0;
    used = 0;
    files = 0;
  endtask
  task automatic alloc(input int sz, input logic sec);
    int b;
    logic ok;
    i_fs_req = '{25'(sz), sec};
    // strobe stays up between back-to-back requests
    i_fs_alloc = 1;
    @(negedge i_clk);
    b = (sz + 4095) / 4096;
    if (b == 0) b = 1;
    if (sec) b = b * 2;
    ok = sz <= 32'h1000000 && files < 128 && used + b <= int'(i_fs_region_blocks);
    chk("fs ok", o_fs_ok, ok);
    chk("fs fail", o_fs_fail, !ok);
    if (ok) begin
      chk("fs addr", o_fs_addr, used * 4096);
      chk("fs blocks", o_fs_blocks, b);
      used += b;
      files++;
    end
    chk("fs files", o_fs_files, files);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1500000;
    error_cnt++;
    test_done();
  end
  initial begin
    sfch_op_t eo[3];
    logic [31:0] a;
    logic [31:0] wa[5];
    logic [15:0] bl[2];
    eo = '{OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_PAGE_PROGRAM};
    bl = '{16'h0, 16'h100};
    void'($urandom(97895));
    repeat (16) @(posedge i_clk);
    @(negedge i_clk);
    i_srst = 0;
    repeat (8) @(negedge i_clk);
    run(OP_READ_ID, 24'h0, 16'h0);
    chk("id count", rq.size(), 3);
    chk("id", {rq[0], rq[1], rq[2]}, FID);
    chk("id op", u_flash.ops[0], 8'h9f);
    run(OP_READ_STATUS, 24'h0, 16'h0);
    chk("st count", rq.size(), 1);
    chk("st", rq[0], 8'h00);
    run(OP_WRITE_ENABLE, 24'h0, 16'h0);
    chk("we op", u_flash.ops[0], 8'h06);
    chk("wel", o_status[1], 1);
    foreach (eo[i]) begin
      a = $urandom;
      run(eo[i], a[23:0], 16'hff);
      chk("we first", u_flash.ops[0], 8'h06);
      chk("not busy", o_status[0], 0);
      chk("opcode", u_flash.cop, i == 0 ? 8'hc7 : i == 1 ? 8'h20 : 8'h02);
      if (i == 1) chk("sector", u_flash.adr, a[23:0] & 24'hfff000);
    end
    chk("prog len", u_flash.pq.size(), 255);
    chk("prog taken", wq.size(), 255);
    foreach (wq[k]) chk("prog data", u_flash.pq[k], wq[k]);
    foreach (bl[i]) begin
      run(OP_PAGE_PROGRAM, 24'h0, bl[i]);
      chk("refused", gerr, 1);
      chk("no frame", u_flash.ops.size(), 0);
    end
    a = $urandom;
    run(OP_READ_DATA, a[23:0], 16'h5);
    chk("rd addr", u_flash.adr, a[23:0]);
    for (int k = 0; k < 5; k++) chk("rd", rq[k], 8'(a + k) ^ 8'h5a);
    run(OP_READ_PARAMS, 24'h0, 16'h2);
    for (int k = 0; k < 2; k++) chk("param", rq[k], 8'ha0 + 8'(k));
    fmt();
    alloc(32'h1000000, 0);
    alloc(32'h1000001, 0);
    fmt();
    alloc(0, 0);
    alloc(1, 1);
    repeat (6) alloc($urandom_range(9000), 1'($urandom_range(1)));
    i_fs_region_blocks = 16'h0100;
    fmt();
    repeat (130) alloc(1, 0);
    fmt();
    repeat (40) alloc(8192, 1'($urandom_range(1)));
    i_fs_alloc = 0;
    $display("test file_store done");
    wa = '{32'h44020000, 32'h44020fff, 32'h44021000, 32'h4401ffff, $urandom};
    foreach (wa[i]) begin
      i_win_addr = wa[i];
      @(negedge i_clk);
      chk("win", o_win_hit, wa[i][31:12] == 20'h44020);
    end
    $display("test window done");
    test_done();
  end
endmodule // tb_top
